// *** inc/mbs_regs.svh ***
// Code points, limits and CRC constants of the serial slave query checker.
`ifndef MBS_REGS_SVH
`define MBS_REGS_SVH
`define MBS_FC_READ      8'h03
`define MBS_FC_WSINGLE   8'h06
`define MBS_FC_DIAG      8'h08
`define MBS_FC_WMULTI    8'h10
`define MBS_FC_EXC_FLAG  8'h80
`define MBS_EXC_NONE     8'h00
`define MBS_EXC_FUNC     8'h01
`define MBS_EXC_ADDR     8'h02
`define MBS_EXC_DATA     8'h03
`define MBS_EXC_SLAVE    8'h04
`define MBS_CE_ADDR      8'h88
`define MBS_CE_SESSION   8'h89
`define MBS_CE_NVM       8'h8a
`define MBS_CE_RANGE     8'h8c
`define MBS_CE_DISABLED  8'h8d
`define MBS_ADDR_MAX     16'h1fff
`define MBS_ADDR_END     17'h02000
`define MBS_MAX_REGS     16
`define MBS_LEN_FIXED    9'h006
`define MBS_LEN_MULTI    9'h007
`define MBS_LEN_SAT      9'h1ff
`define MBS_CRC_PRESET   16'hffff
`define MBS_CRC_POLY     16'ha001
`define MBS_QHDR_BYTES   7
`endif

// *** inc/mbs_pkg.sv ***
// Types shared by the serial slave query checker.
package mbs_pkg;
  typedef enum logic [3:0] {
    S_RX    = 4'h0,
    S_CHECK = 4'h1,
    S_EXC   = 4'h2,
    S_RHDR  = 4'h3,
    S_FETCH = 4'h4,
    S_WAIT  = 4'h5,
    S_HI    = 4'h6,
    S_LO    = 4'h7,
    S_CRCL  = 4'h8,
    S_CRCH  = 4'h9
  } mbs_state_e;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } mbs_byte_s;
endpackage

// *** logic/mbs_slave.sv ***
// Query checker, exception responder and holding-register reader of the serial slave.
// How it works
// R1 - Unsupported function code gets exception 01h.
// R2 - Diagnosis query with sub-function other than 00h gets exception 01h.
// R3 - Start address outside 0000h..1FFFh gets exception 02h.
// R4 - Start address plus count reaching 2000h gets exception 02h.
// R5 - Register count zero or above the limit gets exception 03h.
// R6 - Byte count not twice the register count gets exception 03h.
// R7 - Query length wrong for its function gets exception 03h.
// R8 - Invalid data address also logs communication error 88h.
// R9 - Active tool or operator session gives exception 04h, logs 89h.
// R10 - Memory work, internal busy or memory alarm gives 04h, logs 8Ah.
// R11 - Write value outside setting range gives 04h, logs 8Ch.
// R12 - Execution disabled gives 04h, logs 8Dh.
// R13 - Function 03h returns up to 16 registers of 16 bits.
// R14 - Registers are fetched and sent in ascending address order.
// R15 - Master sends address and count high byte first, check low first.
// R16 - Read reply echoes address and function, then byte count twice count.
// R17 - Registers go high byte first; check value goes low byte first.
// R18 - Master reads both halves of a 32-bit value in one request.
// R19 - Exception reply is function plus 80h, code byte, then check value.
// R20 - Check is CRC-16, preset FFFFh, right shifts, polynomial A001h.
// R21 - Checks run function, address, data, then slave state; first wins.
`timescale 1ns/1ps
`include "mbs_regs.svh"
module mbs_slave #(
  parameter int unsigned MAX_REGS = `MBS_MAX_REGS
) (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire logic               rx_valid,
  output logic                    rx_ready,
  input  wire mbs_pkg::mbs_byte_s rx_byte,
  output logic                    tx_valid,
  input  wire logic               tx_ready,
  output mbs_pkg::mbs_byte_s      tx_byte,
  output logic                    rd_req,
  output logic [15:0]             rd_addr,
  input  wire logic               rd_ack,
  input  wire logic [15:0]        rd_data,
  input  wire logic               tool_session,
  input  wire logic               nvm_busy,
  input  wire logic               internal_busy_output,
  input  wire logic               mem_alarm,
  input  wire logic               write_value_bad,
  input  wire logic               exec_disabled,
  output logic                    err_valid,
  output logic [7:0]              err_code,
  output logic                    fwd_valid
);

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `MBS_CRC_POLY) : (c >> 1); // see R20
    end
    return c;
  endfunction

  function automatic logic fc_supported(input logic [7:0] fc);
    return fc == `MBS_FC_READ || fc == `MBS_FC_WSINGLE || fc == `MBS_FC_DIAG
        || fc == `MBS_FC_WMULTI;
  endfunction

  mbs_pkg::mbs_state_e state_reg;
  mbs_pkg::mbs_state_e state_next;
  logic [7:0]          q_mem [0:`MBS_QHDR_BYTES-1];
  logic [8:0]          len_reg;
  logic [1:0]          idx_reg;
  logic [15:0]         crc_reg;
  logic [7:0]          exc_reg;
  logic [4:0]          done_reg;
  logic [15:0]         rd_hold_reg;
  logic                rd_req_reg;
  logic [15:0]         rd_addr_reg;
  logic                err_valid_reg;
  logic [7:0]          err_code_reg;
  logic                fwd_valid_reg;
  logic                rx_ready_reg;
  mbs_pkg::mbs_byte_s  head_reg;
  mbs_pkg::mbs_byte_s  tail_reg;
  logic                head_v_reg;
  logic                tail_v_reg;

  // Query field decode; the bytes past the header only matter for length.
  wire logic [7:0]  func_w   = q_mem[1];
  wire logic [15:0] addr_w   = {q_mem[2], q_mem[3]};
  wire logic [15:0] cnt_w    = {q_mem[4], q_mem[5]};
  wire logic [7:0]  bcnt_w   = q_mem[6];
  wire logic        is_read  = func_w == `MBS_FC_READ;
  wire logic        is_wmul  = func_w == `MBS_FC_WMULTI;
  wire logic        is_multi = is_read | is_wmul;
  wire logic        is_write = is_wmul | (func_w == `MBS_FC_WSINGLE);
  wire logic        is_diag  = func_w == `MBS_FC_DIAG;
  wire logic [16:0] end_w    = {1'b0, addr_w} + {1'b0, cnt_w};
  wire logic [8:0]  exp_len  = is_wmul ? `MBS_LEN_MULTI + {1'b0, bcnt_w} : `MBS_LEN_FIXED;

  wire logic func_bad = !fc_supported(func_w) // see R1
                      | (is_diag & (addr_w != 16'h0000)); // see R2
  wire logic addr_bad = !is_diag & ((addr_w > `MBS_ADDR_MAX) // see R3
                      | (is_multi & (end_w >= `MBS_ADDR_END))); // see R4
  wire logic cnt_bad  = is_multi & ((cnt_w == 16'h0000) | (cnt_w > 16'(MAX_REGS))); // see R5
  wire logic bcnt_bad = is_wmul & ({8'h00, bcnt_w} != {cnt_w[14:0], 1'b0}); // see R6
  wire logic len_bad  = len_reg != exp_len; // see R7
  wire logic data_bad = cnt_bad | bcnt_bad | len_bad;

  // Slave-state causes, highest first.
  wire logic [7:0] state_err = tool_session ? `MBS_CE_SESSION // see R9
    : (nvm_busy | internal_busy_output | mem_alarm) ? `MBS_CE_NVM // see R10
    : (is_write & write_value_bad) ? `MBS_CE_RANGE // see R11
    : exec_disabled ? `MBS_CE_DISABLED // see R12
    : `MBS_EXC_NONE;

  wire logic [7:0] exc_w = func_bad ? `MBS_EXC_FUNC // see R21
    : addr_bad ? `MBS_EXC_ADDR
    : data_bad ? `MBS_EXC_DATA
    : (state_err != `MBS_EXC_NONE) ? `MBS_EXC_SLAVE
    : `MBS_EXC_NONE;
  wire logic [7:0] log_w = (exc_w == `MBS_EXC_ADDR) ? `MBS_CE_ADDR // see R8
    : (exc_w == `MBS_EXC_SLAVE) ? state_err : `MBS_EXC_NONE;

  // Reply byte generation.
  wire logic in_exc   = state_reg == mbs_pkg::S_EXC;
  wire logic in_crc   = (state_reg == mbs_pkg::S_CRCL) | (state_reg == mbs_pkg::S_CRCH);
  wire logic emitting = in_exc | in_crc | (state_reg == mbs_pkg::S_RHDR)
                      | (state_reg == mbs_pkg::S_HI) | (state_reg == mbs_pkg::S_LO);
  wire logic buf_rdy  = !tail_v_reg;
  wire logic push_w   = emitting & buf_rdy;
  wire logic hdr_end  = idx_reg == 2'd2;
  wire logic last_w   = {11'h000, done_reg} + 16'h0001 == cnt_w;
  wire logic [7:0] hdr_w = (idx_reg == 2'd0) ? q_mem[0]
    : (idx_reg == 2'd1) ? (in_exc ? func_w | `MBS_FC_EXC_FLAG : func_w) // see R19
    : (in_exc ? exc_reg : {cnt_w[6:0], 1'b0}); // see R16
  wire logic [7:0] push_data = (state_reg == mbs_pkg::S_HI) ? rd_hold_reg[15:8] // see R17
    : (state_reg == mbs_pkg::S_LO) ? rd_hold_reg[7:0]
    : (state_reg == mbs_pkg::S_CRCL) ? crc_reg[7:0]
    : (state_reg == mbs_pkg::S_CRCH) ? crc_reg[15:8]
    : hdr_w;
  wire mbs_pkg::mbs_byte_s push_byte = '{data: push_data,
                                         last: state_reg == mbs_pkg::S_CRCH};
  wire logic rx_take = (state_reg == mbs_pkg::S_RX) & rx_valid & rx_ready_reg;
  wire logic pop_w   = head_v_reg & tx_ready;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      mbs_pkg::S_RX: begin
        if (rx_take && rx_byte.last) begin
          state_next = mbs_pkg::S_CHECK;
        end
      end
      mbs_pkg::S_CHECK: begin
        if (exc_w != `MBS_EXC_NONE) begin
          state_next = mbs_pkg::S_EXC;
        end else if (is_read) begin
          state_next = mbs_pkg::S_RHDR; // see R13
        end else begin
          state_next = mbs_pkg::S_RX;
        end
      end
      mbs_pkg::S_EXC: begin
        if (push_w && hdr_end) begin
          state_next = mbs_pkg::S_CRCL;
        end
      end
      mbs_pkg::S_RHDR: begin
        if (push_w && hdr_end) begin
          state_next = mbs_pkg::S_FETCH;
        end
      end
      mbs_pkg::S_FETCH: state_next = mbs_pkg::S_WAIT;
      mbs_pkg::S_WAIT: state_next = rd_ack ? mbs_pkg::S_HI : state_reg;
      mbs_pkg::S_HI:   state_next = push_w ? mbs_pkg::S_LO : state_reg;
      mbs_pkg::S_LO: begin
        if (push_w) begin
          state_next = last_w ? mbs_pkg::S_CRCL : mbs_pkg::S_FETCH;
        end
      end
      mbs_pkg::S_CRCL: state_next = push_w ? mbs_pkg::S_CRCH : state_reg;
      mbs_pkg::S_CRCH: state_next = push_w ? mbs_pkg::S_RX : state_reg;
      default: state_next = mbs_pkg::S_RX;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= mbs_pkg::S_RX;
      rx_ready_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      rx_ready_reg <= state_next == mbs_pkg::S_RX;
    end
  end

  // Only the header bytes are kept; longer frames are just counted.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `MBS_QHDR_BYTES; i++) begin
        q_mem[i] <= 8'h00;
      end
      len_reg <= 9'h000;
    end else if (state_reg == mbs_pkg::S_CHECK) begin
      len_reg <= 9'h000;
    end else if (rx_take) begin
      if (len_reg < 9'(`MBS_QHDR_BYTES)) begin
        q_mem[len_reg[2:0]] <= rx_byte.data;
      end
      if (len_reg != `MBS_LEN_SAT) begin
        len_reg <= len_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idx_reg <= 2'd0;
      crc_reg <= `MBS_CRC_PRESET;
      exc_reg <= `MBS_EXC_NONE;
    end else if (state_reg == mbs_pkg::S_CHECK) begin
      idx_reg <= 2'd0;
      crc_reg <= `MBS_CRC_PRESET;
      exc_reg <= exc_w;
    end else if (push_w) begin
      idx_reg <= hdr_end ? 2'd0 : idx_reg + 2'd1;
      crc_reg <= in_crc ? crc_reg : crc_byte(crc_reg, push_data); // see R20
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      err_valid_reg <= 1'b0;
      err_code_reg  <= 8'h00;
      fwd_valid_reg <= 1'b0;
    end else begin
      err_valid_reg <= (state_reg == mbs_pkg::S_CHECK) & (log_w != `MBS_EXC_NONE);
      err_code_reg  <= (state_reg == mbs_pkg::S_CHECK) ? log_w : err_code_reg;
      fwd_valid_reg <= (state_reg == mbs_pkg::S_CHECK) & (exc_w == `MBS_EXC_NONE) & !is_read;
    end
  end

  // One fetch per register, addresses rising from the start address.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      done_reg    <= 5'd0;
      rd_req_reg  <= 1'b0;
      rd_addr_reg <= 16'h0000;
      rd_hold_reg <= 16'h0000;
    end else begin
      rd_req_reg <= state_reg == mbs_pkg::S_FETCH;
      if (state_reg == mbs_pkg::S_CHECK) begin
        done_reg <= 5'd0;
      end else if (push_w && state_reg == mbs_pkg::S_LO) begin
        done_reg <= done_reg + 5'd1;
      end
      if (state_reg == mbs_pkg::S_FETCH) begin
        rd_addr_reg <= addr_w + {11'h000, done_reg}; // see R14
      end
      if (state_reg == mbs_pkg::S_WAIT && rd_ack) begin
        rd_hold_reg <= rd_data;
      end
    end
  end

  // Two-entry buffer: a stalled receiver holds the reply without losing a byte.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      head_reg   <= '0;
      tail_reg   <= '0;
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
    end else if (pop_w) begin
      head_reg   <= tail_v_reg ? tail_reg : push_byte;
      head_v_reg <= tail_v_reg | push_w;
      tail_v_reg <= 1'b0;
    end else if (push_w) begin
      if (head_v_reg) begin
        tail_reg   <= push_byte;
        tail_v_reg <= 1'b1;
      end else begin
        head_reg   <= push_byte;
        head_v_reg <= 1'b1;
      end
    end
  end

  assign rx_ready  = rx_ready_reg;
  assign tx_valid  = head_v_reg;
  assign tx_byte   = head_reg;
  assign rd_req    = rd_req_reg;
  assign rd_addr   = rd_addr_reg;
  assign err_valid = err_valid_reg;
  assign err_code  = err_code_reg;
  assign fwd_valid = fwd_valid_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire logic chk = state_reg == mbs_pkg::S_CHECK;

  func_code_a: assert property (chk && !fc_supported(func_w) |=> exc_reg == 8'h01) // see R1
    else $error("unsupported function not answered with 01h");
  diag_sub_a: assert property (chk && is_diag && addr_w != 16'h0000 |=> exc_reg == 8'h01) // see R2
    else $error("bad diagnosis sub-function not answered with 01h");
  addr_span_a: assert property (chk && is_read && addr_w > 16'h1fff |=> exc_reg == 8'h02) // see R3
    else $error("out-of-span address not answered with 02h");
  addr_end_a: assert property (chk && is_read && end_w >= 17'h02000 |=> exc_reg == 8'h02) // see R4
    else $error("address end overflow not answered with 02h");
  reg_count_a: assert property (chk && is_read && addr_w < 16'h1000 && cnt_w == 16'h0000
    |=> exc_reg == 8'h03) // see R5
    else $error("zero count not answered with 03h");
  byte_count_a: assert property (chk && !func_bad && !addr_bad && bcnt_bad
    |=> exc_reg == 8'h03) // see R6
    else $error("byte count mismatch not answered with 03h");
  addr_log_a: assert property (chk && exc_w == 8'h02 |=> err_valid && err_code == 8'h88) // see R8
    else $error("address error not logged as 88h");
  session_a: assert property (chk && !func_bad && !addr_bad && !data_bad && tool_session
    |=> exc_reg == 8'h04 ##0 err_valid && err_code == 8'h89) // see R9
    else $error("tool session not answered with 04h and 89h");
  exc_func_a: assert property (push_w && in_exc && idx_reg == 2'd1
    |-> push_data == (func_w | 8'h80)) // see R19
    else $error("exception function byte lacks 80h");
  read_order_a: assert property (rd_req && $past(done_reg) != 5'd0
    |-> rd_addr == $past(rd_addr, 3) + 16'h0001) // see R14
    else $error("read addresses not ascending");
  byte_count_b_a: assert property (push_w && state_reg == mbs_pkg::S_RHDR && hdr_end
    |-> push_data == {cnt_w[6:0], 1'b0}) // see R16
    else $error("reply byte count not twice register count");

  read_done_c: cover property (state_reg == mbs_pkg::S_LO ##1 state_reg == mbs_pkg::S_CRCL);
  exc_sent_c: cover property (in_exc ##[1:20] tx_valid && tx_byte.last);
  stall_c: cover property (tail_v_reg && !tx_ready);
  fwd_c: cover property (fwd_valid);

endmodule

// *** tb/mbs_regmap_model.sv ***
// Holding-register map model that answers each fetch after a chosen delay.
`timescale 1ns/1ps
module mbs_regmap_model (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [3:0]  delay,
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  output logic             rd_ack,
  output logic [15:0]      rd_data
);
  logic       busy_reg;
  logic [3:0] count_reg;

  // Outside an answer the data toggles, so late sampling shows up as garbage.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg  <= 1'b0;
      count_reg <= 4'h0;
      rd_ack    <= 1'b0;
      rd_data   <= 16'h0000;
    end else begin
      rd_ack  <= 1'b0;
      rd_data <= ~rd_data;
      if (rd_req) begin
        busy_reg  <= 1'b1;
        count_reg <= delay;
      end else if (busy_reg && count_reg != 4'h0) begin
        count_reg <= count_reg - 4'h1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        rd_ack   <= 1'b1;
        rd_data  <= {rd_addr[7:0] ^ 8'h5a, rd_addr[15:8] ^ 8'hc3};
      end
    end
  end
endmodule

// *** tb/mbs_slave_test.sv ***
// Self-checking bench of the serial slave query checker and register reader.
`timescale 1ns/1ps
module mbs_slave_test;
  logic               clock = 1'b0;
  logic               arst_n = 1'b0;
  logic               rx_valid = 1'b0;
  logic               rx_ready;
  mbs_pkg::mbs_byte_s rx_byte = '0;
  logic               tx_valid;
  logic               tx_ready = 1'b1;
  mbs_pkg::mbs_byte_s tx_byte;
  logic               rd_req;
  logic [15:0]        rd_addr;
  logic               rd_ack;
  logic [15:0]        rd_data;
  logic [5:0]         stat = 6'h00;
  logic [3:0]         dly = 4'h0;
  logic               err_valid;
  logic [7:0]         err_code;
  logic               fwd_valid;
  logic               stall = 1'b0;
  logic               done = 1'b0;
  logic               fwd_seen = 1'b0;
  logic [8:0]         err_seen = 9'h000;
  logic [7:0]         sa = 8'h01;
  logic [15:0]        a;
  logic [15:0]        n;
  logic [7:0]         q[$];
  logic [7:0]         e[$];
  logic [7:0]         got[$];
  logic [7:0]         bad_fc[6] = '{8'h00, 8'h01, 8'h04, 8'h07, 8'h11, 8'h83};
  logic [7:0]         sc[6] = '{8'h89, 8'h8a, 8'h8a, 8'h8a, 8'h8c, 8'h8d};
  int                 errors = 0;
  int                 checked = 0;
  integer             seed = 32'h4e32;

  mbs_slave i_mbs_slave (.clock(clock), .arst_n(arst_n), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
    .rd_data(rd_data), .tool_session(stat[5]), .nvm_busy(stat[4]),
    .internal_busy_output(stat[3]), .mem_alarm(stat[2]), .write_value_bad(stat[1]),
    .exec_disabled(stat[0]), .err_valid(err_valid), .err_code(err_code),
    .fwd_valid(fwd_valid));
  mbs_regmap_model i_mbs_regmap_model (.clock(clock), .arst_n(arst_n), .delay(dly),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data));

  always #4 clock = ~clock;

  always @(posedge clock) begin
    #1;
    tx_ready <= stall ? 1'($random(seed)) : 1'b1;
    dly      <= stall ? 4'($random(seed)) : 4'h0;
  end

  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_byte.data);
      if (tx_byte.last) done = 1'b1;
    end
    if (err_valid) err_seen = {1'b1, err_code};
    if (fwd_valid) fwd_seen = 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (d[i]) begin
      c = c ^ {8'h00, d[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction

  task automatic add_crc();
    logic [15:0] c;
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
  endtask

  task automatic rdq(input logic [15:0] ad, input logic [15:0] cnt);
    q = {sa, 8'h03, ad[15:8], ad[7:0], cnt[15:8], cnt[7:0]};
  endtask

  task automatic exp_read(input logic [15:0] ad, input logic [15:0] cnt);
    logic [15:0] w;
    e = {sa, 8'h03, 8'(2 * cnt)};
    for (int i = 0; i < cnt; i++) begin
      w = ad + 16'(i);
      w = {w[7:0] ^ 8'h5a, w[15:8] ^ 8'hc3};
      e.push_back(w[15:8]);
      e.push_back(w[7:0]);
    end
    add_crc();
  endtask

  task automatic run(input logic [8:0] ee, input logic ef);
    int k;
    got = {};
    done = 1'b0;
    fwd_seen = 1'b0;
    err_seen = 9'h000;
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_byte  <= '{data: q[i], last: (i == q.size() - 1)};
      for (k = 0; !rx_ready && k < 1000; k++) @(posedge clock) #1;
      @(posedge clock);
      #1;
    end
    rx_valid <= 1'b0;
    for (k = 0; (ef ? !fwd_seen : !done) && k < 1000; k++) @(posedge clock);
    repeat (8) @(posedge clock);
    #1;
    check(16'(got.size()), 16'(e.size()));
    foreach (e[i]) check({8'h00, got[i]}, {8'h00, e[i]});
    check({7'h00, err_seen}, {7'h00, ee});
    check({15'h0000, fwd_seen}, {15'h0000, ef});
  endtask

  task automatic xr(input logic [7:0] code, input logic [8:0] ee);
    e = {sa, q[1] | 8'h80, code};
    add_crc();
    run(ee, 1'b0);
  endtask

  task automatic fw();
    e = {};
    run(9'h000, 1'b1);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    #1;
    arst_n = 1'b1;
    @(posedge clock);
    #1;
    foreach (bad_fc[i]) begin
      q = {sa, bad_fc[i], 8'h00, 8'h00, 8'h00, 8'h01};
      xr(8'h01, 9'h000);
    end
    q = {sa, 8'h08, 8'h01, 8'h00, 8'h12, 8'h34};
    xr(8'h01, 9'h000);
    q[3] = 8'h01;
    q[2] = 8'h00;
    xr(8'h01, 9'h000);
    q[3] = 8'h00;
    fw();
    $display("test function codes done");
    rdq(16'h2000, 16'h0001);
    xr(8'h02, 9'h188);
    q = {sa, 8'h06, 8'h20, 8'h00, 8'h00, 8'h50};
    xr(8'h02, 9'h188);
    rdq(16'h1ff0, 16'h0010);
    xr(8'h02, 9'h188);
    stall = 1'b1;
    rdq(16'h1fef, 16'h0010);
    exp_read(16'h1fef, 16'h0010);
    run(9'h000, 1'b0);
    stall = 1'b0;
    $display("test address span done");
    rdq(16'h0100, 16'h0000);
    xr(8'h03, 9'h000);
    rdq(16'h0100, 16'h0011);
    xr(8'h03, 9'h000);
    q = {sa, 8'h10, 8'h06, 8'h04, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h03, 8'h20};
    fw();
    q[5] = 8'h03;
    xr(8'h03, 9'h000);
    q[5] = 8'h02;
    q.push_back(8'h00);
    xr(8'h03, 9'h000);
    rdq(16'h0100, 16'h0001);
    q.push_back(8'h00);
    xr(8'h03, 9'h000);
    q = {sa, 8'h06, 8'h02, 8'h4b, 8'h00};
    xr(8'h03, 9'h000);
    q.push_back(8'h50);
    fw();
    $display("test data checks done");
    for (int i = 0; i < 6; i++) begin
      stat = 6'h20 >> i;
      rdq(16'h0402, 16'h0002);
      if (i == 4) exp_read(16'h0402, 16'h0002);
      if (i == 4) run(9'h000, 1'b0);
      else xr(8'h04, {1'b1, sc[i]});
      q = {sa, 8'h06, 8'h02, 8'h4b, 8'h00, 8'h50};
      xr(8'h04, {1'b1, sc[i]});
    end
    stat = 6'h3f;
    xr(8'h04, 9'h189);
    rdq(16'h2000, 16'h0000);
    xr(8'h02, 9'h188);
    stat = 6'h01;
    rdq(16'h0100, 16'h0000);
    xr(8'h03, 9'h000);
    stat = 6'h00;
    $display("test slave state done");
    stall = 1'b1;
    repeat (20) begin
      n = 16'(($random(seed) & 15) + 1);
      a = 16'($random(seed)) & 16'h1fff;
      if (a + n > 16'h1fff) a = 16'h1fff - n;
      sa = 8'($random(seed));
      rdq(a, n);
      exp_read(a, n);
      run(9'h000, 1'b0);
    end
    $display("test random reads done");
    print_verdict();
  end

  initial begin
    #480000;
    errors++;
    print_verdict();
  end
endmodule
